// File: design/hrs_pkg.sv
// Package with register map, field positions, reset values and states.
package hrs_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_FEED = 8'h04;
	localparam logic [7:0] ADDR_APPROACH = 8'h08;
	localparam logic [7:0] ADDR_CREEP = 8'h0C;
	localparam logic [7:0] ADDR_FINAL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_VAR_LO_BIT = 2;
	localparam int CFG_VAR_HI_BIT = 3;
	localparam int CFG_DIR_BIT = 4;
	localparam logic [15:0] CFG_RESET = 16'h0004;
	localparam logic [15:0] CFG_MASK = 16'h001D;
	localparam logic [1:0] VAR_ONE = 2'h0;
	localparam logic [1:0] VAR_TWO = 2'h1;
	localparam logic [1:0] VAR_BAD = 2'h2;
	localparam logic [1:0] VAR_THREE = 2'h3;
	localparam logic [31:0] FEED_RESET = 32'h000000C8;
	localparam logic [31:0] APPROACH_RESET = 32'h00000064;
	localparam logic [31:0] CREEP_RESET = 32'h00000032;
	localparam logic [31:0] FINAL_RESET = 32'h00002000;
	localparam logic [31:0] SPEED_MIN = 32'h00000001;
	localparam logic [31:0] SPEED_MAX = 32'h0003A980;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] SEL_STOP = 2'h0;
	localparam logic [1:0] SEL_FEED = 2'h1;
	localparam logic [1:0] SEL_APPROACH = 2'h2;
	localparam logic [1:0] SEL_CREEP = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_REVERSE = 4'h1,
		ST_FEED = 4'h3,
		ST_APPROACH = 4'h2,
		ST_WAIT_LOW = 4'h6,
		ST_WAIT_INDEX = 4'h7,
		ST_FINAL = 4'h5,
		ST_DONE = 4'h4,
		ST_ERROR = 4'hC
	} hrs_state_e;
endpackage

// File: design/hrs_sync.sv
// Two-stage synchroniser with edge detection on the settled value.
`timescale 1ns/100ps
module hrs_sync (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic asyncIn,
	output logic syncOut,
	output logic riseOut,
	output logic fallOut
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign syncOut = sync_r;
	assign riseOut = sync_r & ~last_r;
	assign fallOut = ~sync_r & last_r;
endmodule

// File: design/home_return_sequencer.sv
// Home-return sequencer with AHB-Lite register slave.
`timescale 1ns/100ps
module home_return_sequencer
	import hrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic homing_mode_select_n,
	input wire logic decel_limit_switch,
	input wire logic encoderIndex,
	input wire logic finalDistanceDone,
	output logic [31:0] speedCommand,
	output logic reverseDir,
	output logic motionActive,
	output logic finalTravelStart,
	output logic [31:0] finalTravelDistance,
	output logic homingDone,
	output logic positionError
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [31:0] feed;
		logic [31:0] approach;
		logic [31:0] creep;
		logic [31:0] finalDist;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] rdata;
		hrs_state_e state;
		logic [1:0] speedSel;
		logic rev;
		logic startPulse;
		logic done;
		logic posErr;
		logic [31:0] speedOut;
		logic reqPrev;
	} hrs_regs_s;

	hrs_regs_s cur_r;
	hrs_regs_s cur_nxt;
	logic modeSync;
	logic modeRise;
	logic modeFall;
	logic limitLvl;
	logic limitRise;
	logic limitFall;
	logic indexLvl;
	logic indexRise;
	logic indexFall;
	logic doneLvl;
	logic doneRise;
	logic doneFall;
	logic addrPhase;
	logic [1:0] variant;
	logic homeDir;
	logic [31:0] status;

	hrs_sync modeSyncI (.core_clk(core_clk), .rst(rst),
		.asyncIn(homing_mode_select_n), .syncOut(modeSync),
		.riseOut(modeRise), .fallOut(modeFall));
	hrs_sync limitSyncI (.core_clk(core_clk), .rst(rst),
		.asyncIn(decel_limit_switch), .syncOut(limitLvl),
		.riseOut(limitRise), .fallOut(limitFall));
	hrs_sync indexSyncI (.core_clk(core_clk), .rst(rst),
		.asyncIn(encoderIndex), .syncOut(indexLvl),
		.riseOut(indexRise), .fallOut(indexFall));
	hrs_sync doneSyncI (.core_clk(core_clk), .rst(rst),
		.asyncIn(finalDistanceDone), .syncOut(doneLvl),
		.riseOut(doneRise), .fallOut(doneFall));

	assign addrPhase = hsel & hready & htrans[1];
	assign variant = cur_r.cfg[CFG_VAR_HI_BIT:CFG_VAR_LO_BIT];
	assign homeDir = cur_r.cfg[CFG_DIR_BIT];
	assign status = {23'h000000, cur_r.reqPrev, cur_r.posErr, cur_r.done,
		1'b0, cur_r.state, 1'b0};

	function automatic logic [31:0] clampSpeed(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (v < SPEED_MIN) begin
			r = SPEED_MIN;
		end else if (v > SPEED_MAX) begin
			r = SPEED_MAX;
		end
		return r;
	endfunction

	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.startPulse = 1'b0;
		cur_nxt.rdata = 32'h00000000;
		// Bus data phase of a write lands here.
		if (cur_r.wrPend) begin
			cur_nxt.wrPend = 1'b0;
			unique case (cur_r.wrAddr)
				ADDR_CONFIG: cur_nxt.cfg = hwdata[15:0] & CFG_MASK;
				ADDR_FEED: cur_nxt.feed = clampSpeed(hwdata);
				ADDR_APPROACH: cur_nxt.approach = clampSpeed(hwdata);
				ADDR_CREEP: cur_nxt.creep = clampSpeed(hwdata);
				ADDR_FINAL: cur_nxt.finalDist = hwdata;
				default: cur_nxt.wrPend = 1'b0;
			endcase
		end
		if (addrPhase) begin
			cur_nxt.wrPend = hwrite;
			cur_nxt.wrAddr = haddr[7:0];
			if (!hwrite) begin
				unique case (haddr[7:0])
					ADDR_CONFIG: cur_nxt.rdata = {16'h0000, cur_r.cfg};
					ADDR_FEED: cur_nxt.rdata = cur_r.feed;
					ADDR_APPROACH: cur_nxt.rdata = cur_r.approach;
					ADDR_CREEP: cur_nxt.rdata = cur_r.creep;
					ADDR_FINAL: cur_nxt.rdata = cur_r.finalDist;
					ADDR_STATUS: cur_nxt.rdata = status;
					default: cur_nxt.rdata = 32'h00000000;
				endcase
			end
		end
		cur_nxt.reqPrev = ~modeSync;
		if (modeSync) begin
			cur_nxt.state = ST_IDLE;
			cur_nxt.speedSel = SEL_STOP;
		end else begin
			unique case (cur_r.state)
				ST_IDLE: begin
					if (modeFall && cur_r.cfg[CFG_ENABLE_BIT] &&
						variant != VAR_BAD) begin
						cur_nxt.done = 1'b0;
						cur_nxt.posErr = 1'b0;
						cur_nxt.rev = homeDir;
						unique case (variant)
							VAR_ONE: begin
								if (limitLvl) begin
									cur_nxt.state = ST_WAIT_LOW;
									cur_nxt.speedSel = SEL_APPROACH;
								end else begin
									cur_nxt.state = ST_FEED;
									cur_nxt.speedSel = SEL_FEED;
								end
							end
							VAR_TWO: begin
								// limit high is a position error
								if (limitLvl) begin
									cur_nxt.state = ST_ERROR;
									cur_nxt.posErr = 1'b1;
								end else begin
									cur_nxt.state = ST_APPROACH;
									cur_nxt.speedSel = SEL_APPROACH;
								end
							end
							default: begin
								if (limitLvl) begin
									cur_nxt.state = ST_WAIT_LOW;
									cur_nxt.speedSel = SEL_APPROACH;
								end else begin
									cur_nxt.state = ST_REVERSE;
									cur_nxt.speedSel = SEL_FEED;
									cur_nxt.rev = ~homeDir;
								end
							end
						endcase
					end
				end
				ST_REVERSE: begin
					if (limitRise) begin
						cur_nxt.state = ST_FEED;
						cur_nxt.rev = homeDir;
					end
				end
				ST_FEED: begin
					if (variant == VAR_ONE && limitRise) begin
						cur_nxt.state = ST_WAIT_LOW;
						cur_nxt.speedSel = SEL_APPROACH;
					end else if (variant == VAR_THREE && limitFall) begin
						cur_nxt.state = ST_WAIT_INDEX;
						cur_nxt.speedSel = SEL_APPROACH;
					end
				end
				ST_APPROACH: begin
					// rising limit gives creep and final travel
					if (limitRise) begin
						cur_nxt.state = ST_FINAL;
						cur_nxt.speedSel = SEL_CREEP;
						cur_nxt.startPulse = 1'b1;
					end
				end
				ST_WAIT_LOW: begin
					// limit back low arms index search
					if (limitFall) begin
						cur_nxt.state = ST_WAIT_INDEX;
					end
				end
				ST_WAIT_INDEX: begin
					// first index gives creep and travel
					if (indexRise) begin
						cur_nxt.state = ST_FINAL;
						cur_nxt.speedSel = SEL_CREEP;
						cur_nxt.startPulse = 1'b1;
					end
				end
				ST_FINAL: begin
					if (doneRise) begin
						cur_nxt.state = ST_DONE;
						cur_nxt.speedSel = SEL_STOP;
						cur_nxt.done = 1'b1;
					end
				end
				ST_DONE: cur_nxt.state = ST_DONE;
				ST_ERROR: cur_nxt.speedSel = SEL_STOP;
				default: cur_nxt.state = ST_IDLE;
			endcase
		end
		// reverse leg stops for one cycle on its edge
		if (cur_r.state == ST_REVERSE && limitRise) begin
			cur_nxt.speedOut = 32'h00000000;
		end else begin
			unique case (cur_nxt.speedSel)
				SEL_FEED: cur_nxt.speedOut = cur_nxt.feed;
				SEL_APPROACH: cur_nxt.speedOut = cur_nxt.approach;
				SEL_CREEP: cur_nxt.speedOut = cur_nxt.creep;
				default: cur_nxt.speedOut = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_r <= '{cfg: CFG_RESET, feed: FEED_RESET,
				approach: APPROACH_RESET, creep: CREEP_RESET,
				finalDist: FINAL_RESET, wrPend: 1'b0, wrAddr: 8'h00,
				rdata: 32'h00000000, state: ST_IDLE, speedSel: SEL_STOP,
				rev: 1'b0, startPulse: 1'b0, done: 1'b0, posErr: 1'b0,
				speedOut: 32'h00000000, reqPrev: 1'b0};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign hrdata = cur_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign speedCommand = cur_r.speedOut;
	assign reverseDir = cur_r.rev;
	assign motionActive = (cur_r.speedSel != SEL_STOP);
	assign finalTravelStart = cur_r.startPulse;
	assign finalTravelDistance = cur_r.finalDist;
	assign homingDone = cur_r.done;
	assign positionError = cur_r.posErr;

	sequence limitHighAtStart;
		cur_r.state == ST_IDLE && !modeSync && modeFall &&
			cur_r.cfg[CFG_ENABLE_BIT] && limitLvl;
	endsequence

	disabled_no_start_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_r.state == ST_IDLE && !cur_r.cfg[CFG_ENABLE_BIT])
			|=> cur_r.state == ST_IDLE)
		else $error("Homing started while disabled");
	invalid_variant_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_r.state == ST_IDLE && variant == VAR_BAD)
			|=> cur_r.state == ST_IDLE)
		else $error("Homing started with invalid variant");
	var_two_err_a: assert property (@(posedge core_clk) disable iff (rst)
		(limitHighAtStart and variant == VAR_TWO)
			|=> positionError && !motionActive)
		else $error("Missing position error");
	var_one_high_a: assert property (@(posedge core_clk) disable iff (rst)
		(limitHighAtStart and variant == VAR_ONE)
			|=> speedCommand == cur_r.approach)
		else $error("Variant one did not start at approach");
	reverse_leg_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_r.state == ST_REVERSE) |-> reverseDir != homeDir)
		else $error("Reverse leg runs the wrong way");
	creep_on_index_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_r.state == ST_WAIT_INDEX && indexRise && !modeSync)
			|=> finalTravelStart && speedCommand == cur_r.creep)
		else $error("Index did not start creep");
	approach_on_rise_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(cur_r.state == ST_FEED && variant == VAR_ONE && limitRise &&
			!modeSync) |=> speedCommand == cur_r.approach)
		else $error("No approach after limit rise");
	creep_on_rise_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur_r.state == ST_APPROACH && limitRise && !modeSync)
			|=> finalTravelStart ##1 !finalTravelStart)
		else $error("Variant two creep start wrong");
	speed_range_a: assert property (@(posedge core_clk) disable iff (rst)
		cur_r.feed >= SPEED_MIN && cur_r.feed <= SPEED_MAX)
		else $error("Feed speed out of range");
	stop_after_final_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(cur_r.state == ST_FINAL && doneRise && !modeSync)
			|=> homingDone && speedCommand == 32'h00000000)
		else $error("Did not stop after final travel");
endmodule

// File: dv/hrs_machine_model.sv
// Behavioural axis with limit dog, index marks and final travel timing.
`timescale 1ns/100ps
module hrs_machine_model #(
	parameter int DOG_LO = 100,
	parameter int DOG_HI = 139,
	parameter int FIN_LEN = 20
) (
	input wire logic core_clk,
	input wire logic load,
	input wire logic [15:0] startPos,
	input wire logic motionActive,
	input wire logic reverseDir,
	input wire logic finalTravelStart,
	output logic decel_limit_switch,
	output logic encoderIndex,
	output logic finalDistanceDone
);
	logic [15:0] pos = 16'h0000;
	int fin = 0;
	// The dog holds the switch open over one stretch of travel only.
	assign decel_limit_switch = (pos >= DOG_LO) && (pos <= DOG_HI);
	assign finalDistanceDone = (fin > 0) && (fin <= 2);
	always @(posedge core_clk) begin
		if (load)
			pos <= startPos;
		else if (motionActive)
			pos <= reverseDir ? pos - 16'h0001 : pos + 16'h0001;
		encoderIndex <= motionActive && (pos[3:0] == 4'h0);
		if (finalTravelStart)
			fin <= FIN_LEN + 2;
		else if (fin > 0)
			fin <= fin - 1;
	end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the home-return sequencer.
`timescale 1ns/100ps
module tb_top;
	import hrs_pkg::*;
	localparam logic [31:0] FEEDV = 32'h0000012C;
	localparam logic [31:0] APPV = 32'h00000096;
	localparam logic [31:0] CRPV = 32'h00000046;
	localparam logic [31:0] FINV = 32'hFFFFFF00;
	localparam logic [31:0] SKIP = 32'hFFFFFFFF;
	typedef struct {
		logic [15:0] cfg;
		logic [15:0] pos;
		logic [31:0] spd;
		logic rev;
		logic err;
	} hrs_row_s;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic homing_mode_select_n = 1'h1;
	logic load = 1'h0;
	logic [15:0] startPos = 16'h0;
	logic [31:0] hrdata, speedCommand, finalTravelDistance, rd;
	logic hreadyout, hresp, decel_limit_switch, encoderIndex;
	logic finalDistanceDone, reverseDir, motionActive, finalTravelStart;
	logic homingDone, positionError;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	int n, fs;
	// Start speed SKIP leaves the first speed unchecked for that row.
	hrs_row_s rows [8] = '{
		'{16'h0001, 16'h0032, FEEDV, 1'h0, 1'h0},
		'{16'h0001, 16'h0078, APPV, 1'h0, 1'h0},
		'{16'h0005, 16'h0032, APPV, 1'h0, 1'h0},
		'{16'h0005, 16'h0078, 32'h0, 1'h0, 1'h1},
		'{16'h000D, 16'h0078, SKIP, 1'h0, 1'h0},
		'{16'h000D, 16'h00C8, FEEDV, 1'h1, 1'h0},
		'{16'h001D, 16'h0032, FEEDV, 1'h0, 1'h0},
		'{16'h0011, 16'h00C8, FEEDV, 1'h1, 1'h0}
	};
	home_return_sequencer home_return_sequencer_inst (.core_clk, .rst,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .homing_mode_select_n,
		.decel_limit_switch, .encoderIndex, .finalDistanceDone, .speedCommand,
		.reverseDir, .motionActive, .finalTravelStart, .finalTravelDistance,
		.homingDone, .positionError);
	hrs_machine_model hrs_machine_model_inst (.core_clk, .load, .startPos,
		.motionActive, .reverseDir, .finalTravelStart, .decel_limit_switch,
		.encoderIndex, .finalDistanceDone);
	always #2.5 core_clk = ~core_clk;
	task chkv(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Entered just after a rising edge; read data is taken in the data phase.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge core_clk);
		while (hreadyout !== 1'h1) @(posedge core_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(negedge core_clk);
		rd = hrdata;
		@(posedge core_clk);
		while (hreadyout !== 1'h1) @(posedge core_clk);
	endtask
	task home(input logic [15:0] cfg, input logic [15:0] pos);
		bus(1'h1, ADDR_CONFIG, {16'h0000, cfg});
		load <= 1'h1;
		startPos <= pos;
		@(posedge core_clk);
		load <= 1'h0;
		homing_mode_select_n <= 1'h0;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task release_sel;
		@(posedge core_clk);
		homing_mode_select_n <= 1'h1;
		repeat (8) @(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		bus(1'h0, ADDR_CONFIG, 32'h0);
		chkv(rd, {16'h0000, CFG_RESET}, "cfg reset");
		bus(1'h0, ADDR_FEED, 32'h0);
		chkv(rd, FEED_RESET, "feed reset");
		bus(1'h0, ADDR_APPROACH, 32'h0);
		chkv(rd, APPROACH_RESET, "approach reset");
		bus(1'h0, ADDR_CREEP, 32'h0);
		chkv(rd, CREEP_RESET, "creep reset");
		bus(1'h0, ADDR_FINAL, 32'h0);
		chkv(rd, FINAL_RESET, "final reset");
		chkv(finalTravelDistance, FINAL_RESET, "final out");
		bus(1'h0, 8'h40, 32'h0);
		chkv(rd, 32'h0, "unmapped read");
		bus(1'h1, ADDR_FEED, 32'h0);
		bus(1'h0, ADDR_FEED, 32'h0);
		chkv(rd, SPEED_MIN, "speed floor");
		bus(1'h1, ADDR_FEED, SPEED_MAX + 32'h1);
		bus(1'h0, ADDR_FEED, 32'h0);
		chkv(rd, SPEED_MAX, "speed ceiling");
		bus(1'h1, ADDR_CONFIG, 32'h0000FFFF);
		bus(1'h0, ADDR_CONFIG, 32'h0);
		chkv(rd, {16'h0000, CFG_MASK}, "cfg fields");
		bus(1'h1, ADDR_FEED, FEEDV);
		bus(1'h1, ADDR_APPROACH, APPV);
		bus(1'h1, ADDR_CREEP, CRPV);
		bus(1'h1, ADDR_FINAL, FINV);
		for (int k = 0; k < 2; k++) begin
			home(k ? 16'h0009 : 16'h000C, 16'h0032);
			chkv(speedCommand, 32'h0, "no start");
			release_sel();
		end
		foreach (rows[i]) begin
			home(rows[i].cfg, rows[i].pos);
			if (rows[i].spd !== SKIP) begin
				chkv(speedCommand, rows[i].spd, "start speed");
				if (rows[i].spd !== 32'h0)
					chkv({31'h0, reverseDir}, {31'h0, rows[i].rev}, "dir");
			end
			n = 0;
			fs = 0;
			while (homingDone !== 1'h1 && positionError !== 1'h1 && n < 3000) begin
				@(negedge core_clk);
				n++;
				if (fs > 0)
					fs++;
				if (finalTravelStart === 1'h1)
					fs = 1;
				if (fs == 4) begin
					chkv(speedCommand, CRPV, "creep");
					chkv(finalTravelDistance, FINV, "distance");
				end
			end
			chkv({31'h0, positionError}, {31'h0, rows[i].err}, "error");
			chkv({31'h0, homingDone}, {31'h0, ~rows[i].err}, "done");
			chkv({31'h0, fs != 0}, {31'h0, ~rows[i].err}, "travel");
			chkv(speedCommand, 32'h0, "stopped");
			release_sel();
		end
		home(16'h0001, 16'h0032);
		release_sel();
		@(negedge core_clk);
		chkv(speedCommand, 32'h0, "abort speed");
		chkv({31'h0, homingDone}, 32'h0, "abort done");
		conclude;
	end
endmodule
